// ===== core/debug_port_pkg.sv
// shared constants and types of the single-pin debug port
package debug_port_pkg;
	// apb byte offsets
	localparam logic [11:0] CTRL_OFFSET = 12'h000;
	localparam logic [11:0] STATUS_OFFSET = 12'h004;
	// debug_control field positions and reset value
	localparam int HALT_POS = 7;
	localparam int BKPT_EN_POS = 6;
	localparam int ACK_POS = 5;
	localparam int RST_POS = 0;
	localparam logic [7:0] CTRL_RESET = 8'h00;
	localparam logic [7:0] CTRL_WMASK = 8'he0;
	// unlock key and framing
	localparam int KEY_BITS = 32;
	localparam logic [31:0] KEY_DEFAULT = 32'h5a3c_96e1;
	localparam int KEY_BIT_NS = 800;
	localparam int CLK_NS = 50;
	localparam int KEY_BIT_CYCLES = (KEY_BIT_NS + CLK_NS - 1) / CLK_NS;
	localparam int BAUD_LOW_BITS = 8;
	localparam int FRAME_LAST = 9;
	localparam int DIV_W = 16;
	// host commands and the breakpoint opcode
	localparam logic [7:0] CMD_EXEC = 8'h12;
	localparam logic [7:0] CMD_RD_CTRL = 8'h05;
	localparam logic [7:0] CMD_WR_CTRL = 8'h04;
	localparam logic [7:0] BKPT_OPCODE = 8'h00;

	typedef enum logic [2:0] {
		ST_IDLE = 3'b000,
		ST_BAUD = 3'b001,
		ST_RX = 3'b010,
		ST_TX = 3'b011
	} port_state_e;

	typedef enum logic [1:0] {
		PH_CMD = 2'b00,
		PH_EXEC = 2'b01,
		PH_WCTRL = 2'b10
	} cmd_phase_e;

	typedef struct packed {
		logic valid;
		logic [7:0] data;
	} exec_s;
endpackage

// ===== core/single_pin_debug_port.sv
// single-pin on-chip debugger port with apb register access
//
// Overview of operation
// R01: reset pin low plus a 32-bit key on the debug pin unlocks debug access.
// R02: after unlock and reset pin high, autobaud runs, then debug state is reachable.
// R03: writing zero to the debug-state bit leaves the halted state.
// R04: power-on, brownout, watchdog or reset pin low leave the halted state.
// R05: debug line low during stop mode gives a system reset and exits debug.
// R06: characters are start bit, eight data bits lsb first, stop bit.
// R07: a reply may start right after the stop bit is sampled.
// R08: host drives the line high at most half a bit during stop.
// R09: host should drive the line open-drain.
// R10: after reset the port sends nothing until a character arrives.
// R11: host's first character is 80h, eight bit times low.
// R12: the low period of the first character sets the rx and tx bit time.
// R13: execute command without debug state or with read protect discards one byte.
// R14: debug-state bit one stops fetching; it reads one while halted.
// R15: clearing the debug-state bit resumes fetching.
// R16: breakpoint opcode with breakpoints enabled sets the debug-state bit.
// R17: under read protect, zero writes to the debug-state bit are ignored.
// R18: with breakpoints disabled the breakpoint opcode is a no-operation.
// R19: writing the reset bit resets the whole device.
// R20: baud detector counts clocks over the low period to get the divisor.
//
// Added by the designer: the APB slave port and the address map.
`timescale 1ns/1ps
module single_pin_debug_port #(
	parameter logic [31:0] UNLOCK_KEY = debug_port_pkg::KEY_DEFAULT,
	parameter int KEY_CYCLES = debug_port_pkg::KEY_BIT_CYCLES
) (
	input wire logic clk,
	input wire logic rstn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic serial_debug_pin_in,
	output logic serial_debug_pin_out,
	output logic serial_debug_pin_oe,
	input wire logic shared_reset_pin_in,
	input wire logic por_event,
	input wire logic brownout_event,
	input wire logic watchdog_event,
	input wire logic stop_mode,
	input wire logic read_protect,
	input wire logic bkpt_decoded,
	output logic fetch_stall,
	output logic bkpt_as_nop,
	output logic system_reset_req,
	output logic unlocked,
	output debug_port_pkg::exec_s exec_out
);
	import debug_port_pkg::*;

	////////////////////////////////////////////////////////////////////////
	// pin synchronisers
	logic line_s1, line_s2, rp_s1, rp_s2;
	always_ff @(posedge clk) begin
		line_s1 <= rstn ? serial_debug_pin_in : 1'b1;
		line_s2 <= rstn ? line_s1 : 1'b1;
		rp_s1 <= rstn ? shared_reset_pin_in : 1'b1;
		rp_s2 <= rstn ? rp_s1 : 1'b1;
	end

	////////////////////////////////////////////////////////////////////////
	// unlock key capture, msb first, while the reset pin is held low
	logic key_run_reg, unlocked_reg;
	logic [15:0] kcnt_reg;
	logic [5:0] kbits_reg;
	logic [31:0] ksh_reg;
	wire key_tick = key_run_reg && kcnt_reg == 16'h0000;
	wire [31:0] ksh_next = {ksh_reg[30:0], line_s2};
	always_ff @(posedge clk) begin
		if (!rstn || rp_s2) begin
			key_run_reg <= 1'b0;
			kcnt_reg <= 16'h0000;
			kbits_reg <= 6'h00;
			ksh_reg <= 32'h0000_0000;
		end else if (!key_run_reg) begin
			key_run_reg <= !line_s2;
			kcnt_reg <= 16'(KEY_CYCLES / 2);
		end else if (key_tick && kbits_reg != 6'(KEY_BITS)) begin
			ksh_reg <= ksh_next;
			kbits_reg <= kbits_reg + 6'h01;
			kcnt_reg <= 16'(KEY_CYCLES - 1);
		end else if (!key_tick) begin
			kcnt_reg <= kcnt_reg - 16'h0001;
		end
	end
	// cleared only by the core reset, so a pin reset keeps the unlock
	always_ff @(posedge clk) begin
		if (!rstn)
			unlocked_reg <= 1'b0;
		else if (kbits_reg == 6'(KEY_BITS) && ksh_reg == UNLOCK_KEY)
			unlocked_reg <= 1'b1; // see R01
	end
	assign unlocked = unlocked_reg;

	////////////////////////////////////////////////////////////////////////
	// autobaud, receiver, transmitter and command decode
	port_state_e state_reg;
	cmd_phase_e phase_reg;
	logic baud_ok_reg, host_wr_reg;
	logic [DIV_W-1:0] div_reg, cnt_reg;
	logic [3:0] bitn_reg;
	logic [7:0] rx_reg, host_wdata_reg;
	logic [9:0] tx_reg;
	exec_s exec_reg;
	logic [7:0] ctrl_reg;
	wire tick = cnt_reg == '0;
	wire [7:0] rx_byte = rx_reg;
	wire [DIV_W-1:0] meas_div = cnt_reg >> 3; // see R20
	wire frame_end = state_reg == ST_RX && tick && bitn_reg == 4'(FRAME_LAST);
	wire exec_ok = ctrl_reg[HALT_POS] && !read_protect;
	always_ff @(posedge clk) begin
		host_wr_reg <= 1'b0;
		exec_reg.valid <= 1'b0;
		if (!rstn || !rp_s2) begin
			state_reg <= ST_IDLE; // see R10
			phase_reg <= PH_CMD;
			cnt_reg <= '0;
			bitn_reg <= 4'h0;
			tx_reg <= 10'h3ff;
			rx_reg <= 8'h00;
			host_wdata_reg <= 8'h00;
			exec_reg.data <= 8'h00;
			if (!rstn) begin
				baud_ok_reg <= 1'b0;
				div_reg <= '0;
			end
		end else begin
			case (state_reg)
			ST_IDLE: begin
				if (unlocked_reg && !line_s2) begin // see R02
					state_reg <= baud_ok_reg ? ST_RX : ST_BAUD;
					cnt_reg <= baud_ok_reg ? div_reg >> 1 : DIV_W'(1);
					bitn_reg <= 4'h0;
				end
			end
			ST_BAUD: begin
				if (!line_s2) begin
					cnt_reg <= cnt_reg + DIV_W'(1); // see R20
				end else begin
					// eight low bit times of 80h give the bit time
					div_reg <= meas_div == '0 ? DIV_W'(1) : meas_div; // see R12
					baud_ok_reg <= 1'b1; // see R11
					state_reg <= ST_IDLE;
				end
			end
			ST_RX: begin
				cnt_reg <= tick ? div_reg - DIV_W'(1) : cnt_reg - DIV_W'(1);
				if (tick) begin
					bitn_reg <= bitn_reg + 4'h1;
					if (bitn_reg == 4'h0 && line_s2)
						state_reg <= ST_IDLE; // glitch, not a start bit
					else if (bitn_reg != 4'(FRAME_LAST))
						rx_reg <= {line_s2, rx_reg[7:1]}; // see R06
					else begin
						state_reg <= ST_IDLE;
						phase_reg <= PH_CMD;
						case (phase_reg)
						PH_CMD: begin
							if (rx_byte == CMD_EXEC)
								phase_reg <= PH_EXEC;
							else if (rx_byte == CMD_WR_CTRL)
								phase_reg <= PH_WCTRL;
							else if (rx_byte == CMD_RD_CTRL) begin
								// reply starts on the stop-bit sample
								state_reg <= ST_TX; // see R07
								tx_reg <= {1'b1, ctrl_reg, 1'b0};
								bitn_reg <= 4'h0;
							end
						end
						PH_EXEC: begin
							exec_reg.valid <= exec_ok; // see R13
							exec_reg.data <= rx_byte;
						end
						PH_WCTRL: begin
							host_wr_reg <= 1'b1;
							host_wdata_reg <= rx_byte;
						end
						default: phase_reg <= PH_CMD;
						endcase
					end
				end
			end
			ST_TX: begin
				cnt_reg <= tick ? div_reg - DIV_W'(1) : cnt_reg - DIV_W'(1);
				if (tick) begin
					tx_reg <= {1'b1, tx_reg[9:1]}; // see R06
					bitn_reg <= bitn_reg + 4'h1;
					if (bitn_reg == 4'(FRAME_LAST))
						state_reg <= ST_IDLE;
				end
			end
			default: state_reg <= ST_IDLE;
			endcase
		end
	end
	assign serial_debug_pin_out = tx_reg[0];
	assign serial_debug_pin_oe = state_reg == ST_TX; // see R10
	assign exec_out = exec_reg;

	////////////////////////////////////////////////////////////////////////
	// debug_control register
	wire apb_access = psel && penable;
	wire ctrl_hit = paddr == CTRL_OFFSET;
	wire stat_hit = paddr == STATUS_OFFSET;
	wire apb_wr = apb_access && pwrite && ctrl_hit;
	wire wr_any = apb_wr || host_wr_reg;
	wire [7:0] wr_data = apb_wr ? pwdata[7:0] : host_wdata_reg;
	wire stop_reset = stop_mode && !line_s2; // see R05
	wire exit_evt = por_event || brownout_event || watchdog_event || !rp_s2 || stop_reset;
	wire bkpt_hit = bkpt_decoded && ctrl_reg[BKPT_EN_POS];
	// a zero write is dropped under read protect, a breakpoint beats a clear
	wire wr_clear_ok = wr_any && (wr_data[HALT_POS] || !read_protect); // see R17
	wire halt_next = bkpt_hit ? 1'b1 : // see R16
		wr_clear_ok ? wr_data[HALT_POS] : ctrl_reg[HALT_POS]; // see R03
	always_ff @(posedge clk) begin
		if (!rstn || exit_evt) begin
			ctrl_reg <= CTRL_RESET; // see R04
			system_reset_req <= rstn && stop_reset; // see R05
		end else begin
			ctrl_reg[HALT_POS] <= halt_next;
			if (wr_any)
				ctrl_reg[6:5] <= wr_data[6:5];
			system_reset_req <= wr_any && wr_data[RST_POS]; // see R19
		end
	end
	assign fetch_stall = ctrl_reg[HALT_POS]; // see R14 R15
	assign bkpt_as_nop = bkpt_decoded && !ctrl_reg[BKPT_EN_POS]; // see R18

	////////////////////////////////////////////////////////////////////////
	// apb read path, data captured in the setup cycle
	wire [31:0] stat_word = {div_reg, 11'h000, state_reg, baud_ok_reg, unlocked_reg};
	wire [31:0] rd_word = ctrl_hit ? {24'h000000, ctrl_reg & CTRL_WMASK} :
		stat_hit ? stat_word : 32'h0000_0000;
	always_ff @(posedge clk) begin
		if (!rstn)
			prdata <= 32'h0000_0000;
		else if (psel && !penable)
			prdata <= rd_word;
	end
	assign pready = 1'b1;
	assign pslverr = apb_access && !(ctrl_hit || stat_hit || 1'b0) ;

	////////////////////////////////////////////////////////////////////////
	// checks
	prot_hold_a: assert property (@(posedge clk) disable iff (!rstn) // see R17
		read_protect && fetch_stall && !exit_evt |=> fetch_stall)
		else $error("debug state cleared under read protect");
	bkpt_set_a: assert property (@(posedge clk) disable iff (!rstn) // see R16
		bkpt_hit && !exit_evt |=> fetch_stall)
		else $error("breakpoint did not halt");
	bkpt_nop_a: assert property (@(posedge clk) disable iff (!rstn) // see R18
		bkpt_decoded && !ctrl_reg[BKPT_EN_POS] |-> bkpt_as_nop ##1 !$rose(fetch_stall))
		else $error("disabled breakpoint halted");
	exit_reset_a: assert property (@(posedge clk) disable iff (!rstn) // see R04
		por_event || brownout_event || watchdog_event |=> !fetch_stall && ctrl_reg == 8'h00)
		else $error("reset did not leave debug state");
	stop_wake_a: assert property (@(posedge clk) disable iff (!rstn) // see R05
		stop_mode && !line_s2 |=> system_reset_req && !fetch_stall)
		else $error("stop wake reset missing");
	rst_bit_a: assert property (@(posedge clk) disable iff (!rstn) // see R19
		apb_wr && pwdata[RST_POS] && !exit_evt |=> system_reset_req)
		else $error("reset bit ignored");
	clear_run_a: assert property (@(posedge clk) disable iff (!rstn) // see R15
		apb_wr && !pwdata[HALT_POS] && !read_protect && !bkpt_hit |=> !fetch_stall)
		else $error("clear did not resume");
	idle_quiet_a: assert property (@(posedge clk) disable iff (!rstn) // see R10
		!baud_ok_reg |-> !serial_debug_pin_oe)
		else $error("port drove line before autobaud");
	stop_bit_a: assert property (@(posedge clk) disable iff (!rstn) // see R06
		state_reg == ST_TX && bitn_reg == 4'h9 |-> serial_debug_pin_out)
		else $error("stop bit not high");
	reply_now_a: assert property (@(posedge clk) disable iff (!rstn) // see R07
		frame_end && phase_reg == PH_CMD && rx_byte == CMD_RD_CTRL |=>
		serial_debug_pin_oe && !serial_debug_pin_out)
		else $error("reply did not start after stop bit");
	exec_drop_a: assert property (@(posedge clk) disable iff (!rstn) // see R13
		frame_end && phase_reg == PH_EXEC && !exec_ok |=> !exec_out.valid)
		else $error("byte passed outside debug state");
	// a pin reset in the stop-bit cycle drops the byte, hence the rp_s2 term
	exec_pass_a: assert property (@(posedge clk) disable iff (!rstn) // see R13
		frame_end && rp_s2 && phase_reg == PH_EXEC && exec_ok |=>
		exec_out.valid && exec_out.data == $past(rx_byte))
		else $error("exec byte not passed in debug state");
	host_clear_a: assert property (@(posedge clk) disable iff (!rstn) // see R03
		host_wr_reg && !apb_wr && !host_wdata_reg[HALT_POS] && !read_protect && !bkpt_hit
		|=> !fetch_stall)
		else $error("host clear did not resume");
	pin_exit_a: assert property (@(posedge clk) disable iff (!rstn) // see R04
		!rp_s2 |=> !fetch_stall)
		else $error("reset pin did not leave debug state");
	unlock_key_a: assert property (@(posedge clk) disable iff (!rstn) // see R01
		kbits_reg == 6'(KEY_BITS) && ksh_reg == UNLOCK_KEY |=> unlocked)
		else $error("matching key did not unlock");
	baud_gate_a: assert property (@(posedge clk) disable iff (!rstn) // see R02
		state_reg == ST_BAUD |-> unlocked_reg)
		else $error("autobaud ran while locked");
	baud_done_a: assert property (@(posedge clk) disable iff (!rstn) // see R12
		state_reg == ST_BAUD && line_s2 && rp_s2 |=> baud_ok_reg && div_reg != '0)
		else $error("autobaud gave no divisor");
	tx_cause_a: assert property (@(posedge clk) disable iff (!rstn) // see R10
		$rose(serial_debug_pin_oe) |-> $past(frame_end))
		else $error("port sent without a request");
endmodule

// ===== dv/debug_host_model.sv
// partner model: external debug host on the single-wire line
`timescale 1ns/1ps
module debug_host_model (
	input wire logic clk,
	input wire logic line,
	output logic host_low
);
	initial host_low = 1'b0;
	////////////////////////////////////////////////////////////////
	// only ever pulls low; the pull-up or the port makes every high, so no clash
	task automatic hold_bit(input logic b, input int cyc);
		@(posedge clk);
		host_low <= ~b;
		repeat (cyc - 1) @(posedge clk);
	endtask
	task automatic send_byte(input logic [7:0] b, input int div);
		hold_bit(1'b0, div);
		for (int i = 0; i < 8; i++) hold_bit(b[i], div);
		hold_bit(1'b1, div);
	endtask
	// key goes msb first while the reset pin is held low
	task automatic send_key(input logic [31:0] k, input int cyc);
		for (int i = 31; i >= 0; i--) hold_bit(k[i], cyc);
		hold_bit(1'b1, cyc);
	endtask
	// skips our own frame, then waits a bounded time for the reply
	task automatic recv_byte(input int div, output logic [7:0] b, output logic ok);
		ok = 1'b0;
		b = 8'h00;
		// our own last data bit may be low; look for the reply from mid stop bit
		repeat (9 * div + div / 2) @(posedge clk);
		for (int n = 0; n < 4 * div && !ok; n++) begin
			@(posedge clk);
			ok = (line === 1'b0);
		end
		repeat (div / 2) @(posedge clk);
		for (int i = 0; i < 8; i++) begin
			repeat (div) @(posedge clk);
			b[i] = line;
		end
		repeat (div) @(posedge clk);
		ok = ok && (line === 1'b1);
	endtask
endmodule

// ===== dv/single_pin_debug_port_bench.sv
// self-checking bench of the single-pin debug port
`timescale 1ns/1ps
module single_pin_debug_port_bench;
	import debug_port_pkg::*;
	localparam int DIV = 16;
	localparam int KCYC = 4;
	logic clk, rstn, psel, penable, pwrite, pin_rst, por, bo, wdt, stop, rprot, bkpt;
	logic [11:0] paddr;
	logic [31:0] pwdata, prdata, rd;
	logic pready, pslverr, tx, oe, stall, nop, sreq, unl, host_low, err, ok;
	logic [7:0] b, exec_last;
	exec_s exec_out;
	wire line;
	int errors, cmp_count, exec_cnt, sreq_cnt;
	assign line = (oe ? tx : 1'b1) & ~host_low;
	single_pin_debug_port #(.KEY_CYCLES(KCYC)) single_pin_debug_port_inst (.clk(clk),
		.rstn(rstn), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
		.pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
		.serial_debug_pin_in(line), .serial_debug_pin_out(tx), .serial_debug_pin_oe(oe),
		.shared_reset_pin_in(pin_rst), .por_event(por), .brownout_event(bo),
		.watchdog_event(wdt), .stop_mode(stop), .read_protect(rprot), .bkpt_decoded(bkpt),
		.fetch_stall(stall), .bkpt_as_nop(nop), .system_reset_req(sreq), .unlocked(unl),
		.exec_out(exec_out));
	debug_host_model debug_host_model_inst (.clk(clk), .line(line), .host_low(host_low));
	////////////////////////////////////////////////////////////////
	initial begin
		clk = 1'b0;
		forever #25 clk = ~clk;
	end
	always @(posedge clk) begin
		if (exec_out.valid === 1'b1) begin
			exec_cnt++;
			exec_last = exec_out.data;
		end
		if (sreq === 1'b1) sreq_cnt++;
	end
	task automatic end_sim();
		$display("counts: errors %0d compares %0d", errors, cmp_count);
		if (errors == 0 && cmp_count > 0) $display("Simulation passed");
		else $display("Simulation failed");
		$finish;
	endtask
	task automatic check(input logic [31:0] got, input logic [31:0] exp, input string what);
		cmp_count++;
		if (got !== exp) begin
			errors++;
			$display("ERROR %0t %s got %h want %h", $time, what, got, exp);
		end
	endtask
	task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
		@(posedge clk);
		psel <= 1'b1;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		@(posedge clk);
		penable <= 1'b1;
		@(posedge clk);
		while (pready !== 1'b1) @(posedge clk);
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	task automatic pulse_bkpt(input logic exp_nop);
		@(posedge clk);
		bkpt <= 1'b1;
		@(negedge clk);
		check(32'(nop), 32'(exp_nop), "nop");
		@(posedge clk);
		bkpt <= 1'b0;
		repeat (2) @(posedge clk);
	endtask
	////////////////////////////////////////////////////////////////
	task automatic t_link();
		apb(1'b0, CTRL_OFFSET, 32'h0);
		check(rd, 32'(CTRL_RESET), "ctrl reset");
		apb(1'b0, 12'h300, 32'h0);
		check(32'(err), 32'h1, "unmapped");
		@(posedge clk);
		pin_rst <= 1'b0;
		repeat (4) @(posedge clk);
		debug_host_model_inst.send_key(KEY_DEFAULT, KCYC);
		repeat (4) @(posedge clk);
		check(32'(unl), 32'h1, "unlock");
		pin_rst <= 1'b1;
		repeat (4) @(posedge clk);
		check(32'(oe), 32'h0, "idle line");
		debug_host_model_inst.send_byte(8'h80, DIV);
		repeat (4) @(posedge clk);
		apb(1'b0, STATUS_OFFSET, 32'h0);
		check(32'(rd[31:16]), DIV, "divisor");
		apb(1'b1, CTRL_OFFSET, 32'h60);
		fork
			debug_host_model_inst.send_byte(CMD_RD_CTRL, DIV);
			debug_host_model_inst.recv_byte(DIV, b, ok);
		join
		check(32'(ok), 32'h1, "reply framing");
		check(32'(b), 32'h60, "reply data");
		repeat (DIV) @(posedge clk);
		for (int i = 0; i < 2; i++) begin
			debug_host_model_inst.send_byte(CMD_WR_CTRL, DIV);
			debug_host_model_inst.send_byte(i ? 8'h20 : 8'ha0, DIV);
			repeat (2) @(posedge clk);
			check(32'(stall), i ? 32'h0 : 32'h1, "host write");
		end
		apb(1'b0, CTRL_OFFSET, 32'h0);
		check(rd, 32'h20, "host ctrl");
		$display("test link done");
	endtask
	task automatic t_exec();
		int n;
		for (int i = 0; i < 3; i++) begin
			apb(1'b1, CTRL_OFFSET, (i == 1) ? 32'h0 : 32'h80);
			rprot <= (i == 2);
			n = exec_cnt;
			debug_host_model_inst.send_byte(CMD_EXEC, DIV);
			debug_host_model_inst.send_byte(8'(8'ha5 + i), DIV);
			repeat (2 * DIV) @(posedge clk);
			check(32'(exec_cnt - n), (i == 0) ? 32'h1 : 32'h0, "exec");
		end
		check(32'(exec_last), 32'ha5, "exec byte");
		$display("test exec done");
	endtask
	task automatic t_ctrl();
		apb(1'b1, CTRL_OFFSET, 32'h0);
		repeat (2) @(posedge clk);
		check(32'(stall), 32'h1, "protected clear");
		rprot <= 1'b0;
		apb(1'b1, CTRL_OFFSET, 32'h0);
		repeat (2) @(posedge clk);
		check(32'(stall), 32'h0, "resume");
		pulse_bkpt(1'b1);
		check(32'(stall), 32'h0, "bkpt off");
		apb(1'b1, CTRL_OFFSET, 32'h40);
		pulse_bkpt(1'b0);
		check(32'(stall), 32'h1, "bkpt on");
		apb(1'b0, CTRL_OFFSET, 32'h0);
		check(rd, 32'hc0, "ctrl read");
		$display("test ctrl done");
	endtask
	task automatic t_exits();
		int n;
		for (int i = 0; i < 4; i++) begin
			apb(1'b1, CTRL_OFFSET, 32'h80);
			@(posedge clk);
			case (i)
				0: por <= 1'b1;
				1: bo <= 1'b1;
				2: wdt <= 1'b1;
				default: pin_rst <= 1'b0;
			endcase
			repeat (3) @(posedge clk);
			{por, bo, wdt, pin_rst} <= 4'h1;
			repeat (4) @(posedge clk);
			check(32'(stall), 32'h0, "reset exit");
		end
		n = sreq_cnt;
		apb(1'b1, CTRL_OFFSET, 32'h81);
		repeat (3) @(posedge clk);
		check(32'(sreq_cnt > n), 32'h1, "reset bit");
		apb(1'b1, CTRL_OFFSET, 32'h80);
		n = sreq_cnt;
		stop <= 1'b1;
		debug_host_model_inst.hold_bit(1'b0, 4);
		debug_host_model_inst.hold_bit(1'b1, 1);
		repeat (6) @(posedge clk);
		check(32'(sreq_cnt > n), 32'h1, "stop wake");
		check(32'(stall), 32'h0, "stop exit");
		stop <= 1'b0;
		$display("test exits done");
	endtask
	////////////////////////////////////////////////////////////////
	initial begin
		{rstn, psel, penable, pwrite, por, bo, wdt, stop, rprot, bkpt} = 10'h0;
		pin_rst = 1'b1;
		paddr = 12'h000;
		pwdata = 32'h0;
		repeat (10) @(posedge clk);
		rstn <= 1'b1;
		t_link();
		t_exec();
		t_ctrl();
		t_exits();
		end_sim();
	end
	// whole run is a few thousand cycles
	initial begin
		repeat (20000) @(posedge clk);
		errors++;
		$display("ERROR %0t timeout", $time);
		end_sim();
	end
endmodule
